// >>> hw/mfps_top.v
// multi-function pin select for ports a to e with wishbone select registers
`timescale 1ns/1ps
`default_nettype none
`include "mfps_regs.vh"
module mfps_top (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [4:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // gpio block, ports a-e (e bits 0-4)
    input  wire [36:0] gpio_out_i,
    input  wire [36:0] gpio_oe_i,
    output wire [36:0] gpio_in_o,
    // pads
    input  wire [36:0] pad_in_i,
    output wire [36:0] pad_out_o,
    output wire [36:0] pad_oe_o,
    // peripherals
    output wire [5:0]  ext_interrupt_in_o,
    output wire [1:0]  test_clock_o,
    output wire [5:0]  timer_capture_a_o,
    output wire [5:0]  timer_capture_b_o,
    output wire [3:0]  ext_timer_clock_src_o,
    output wire        uart0_receive_o,
    input  wire        uart0_transmit_i,
    output wire        uart1_receive_o,
    input  wire        uart1_transmit_i,
    output wire        uart1_clear_to_send_n_o,
    output wire        uart1_set_ready_n_o,
    output wire        uart1_carrier_detect_n_o,
    output wire        uart1_ring_indicator_n_o,
    input  wire        uart1_terminal_ready_n_i,
    input  wire        uart1_request_send_n_i,
    output wire        smartcard_data_in_o,
    input  wire        smartcard_data_out_i,
    input  wire        smartcard_clock_out_i
);
    reg  [7:0]  port_a_function_select;
    reg  [7:0]  port_b_function_select;
    reg  [7:0]  port_c_function_select;
    reg  [7:0]  port_d_function_select;
    reg  [4:0]  port_e_function_select;
    wire [36:0] sel_periph;
    wire [36:0] periph_is_out;
    wire [36:0] periph_out;
    wire [36:0] periph_in;
    wire        req;
    wire [4:0]  waddr;
    reg  [31:0] next_dat;

    assign req   = cyc_i & stb_i & ~ack_o;
    assign waddr = {adr_i[4:2], 2'b00};

    // one-wait-state slave: ack one cycle after request, dropped next cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            port_a_function_select <= `MFPS_SEL_A_RST;
            port_b_function_select <= `MFPS_SEL_B_RST;
            port_c_function_select <= `MFPS_SEL_C_RST;
            port_d_function_select <= `MFPS_SEL_D_RST;
            port_e_function_select <= `MFPS_SEL_E_RST;
            ack_o                  <= 1'b0;
            dat_o                  <= 32'h00000000;
        end else begin
            ack_o <= req;
            dat_o <= req ? next_dat : 32'h00000000;
            if (req && we_i && sel_i[0]) begin
                if (waddr == {1'b0, `MFPS_SEL_A_ADDR}) begin
                    port_a_function_select <= dat_i[7:0];
                end else if (waddr == {1'b0, `MFPS_SEL_B_ADDR}) begin
                    port_b_function_select <= dat_i[7:0];
                end else if (waddr == {1'b0, `MFPS_SEL_C_ADDR}) begin
                    port_c_function_select <= dat_i[7:0];
                end else if (waddr == {1'b0, `MFPS_SEL_D_ADDR}) begin
                    port_d_function_select <= dat_i[7:0];
                end else if (waddr == {`MFPS_SEL_E_HI, `MFPS_SEL_E_ADDR}) begin
                    port_e_function_select <= dat_i[4:0];
                end
            end
        end
    end

    // unmapped offsets read zero and ignore writes
    always @* begin
        if (waddr == {1'b0, `MFPS_SEL_A_ADDR}) begin
            next_dat = {24'h000000, port_a_function_select};
        end else if (waddr == {1'b0, `MFPS_SEL_B_ADDR}) begin
            next_dat = {24'h000000, port_b_function_select};
        end else if (waddr == {1'b0, `MFPS_SEL_C_ADDR}) begin
            next_dat = {24'h000000, port_c_function_select};
        end else if (waddr == {1'b0, `MFPS_SEL_D_ADDR}) begin
            next_dat = {24'h000000, port_d_function_select};
        end else if (waddr == {`MFPS_SEL_E_HI, `MFPS_SEL_E_ADDR}) begin
            next_dat = {27'h0000000, port_e_function_select};
        end else begin
            next_dat = 32'h00000000;
        end
    end

    // per-pin peripheral select; port c is active high, a6-a7 never select, all others active low
    assign sel_periph[5:0]   = ~port_a_function_select[5:0];
    assign sel_periph[7:6]   = 2'b00;
    assign sel_periph[15:8]  = ~port_b_function_select;
    assign sel_periph[19:16] = port_c_function_select[3:0];
    assign sel_periph[23:20] = port_c_function_select[7:4];
    assign sel_periph[31:24] = ~port_d_function_select;
    assign sel_periph[36:32] = ~port_e_function_select;

    // only transmit, modem-control outputs and smart-card out/clock drive
    // e4,e3 smart-card out, e2 smart-card in, e1,e0 modem outputs; d3,d1 transmit
    assign periph_is_out = {5'b11011, 8'h0A, 24'h000000};
    assign periph_out    = {smartcard_clock_out_i, smartcard_data_out_i, 1'b0,
                            uart1_request_send_n_i, uart1_terminal_ready_n_i,
                            4'h0, uart1_transmit_i, 1'b0, uart0_transmit_i, 1'b0,
                            24'h000000};

    genvar gi;
    generate
        for (gi = 0; gi < 37; gi = gi + 1) begin : g_pin
            mfps_pin_cell u_cell (
                .sel_periph_i    (sel_periph[gi]),
                .periph_is_out_i (periph_is_out[gi]),
                .periph_out_i    (periph_out[gi]),
                .gpio_oe_i       (gpio_oe_i[gi]),
                .gpio_out_i      (gpio_out_i[gi]),
                .pad_in_i        (pad_in_i[gi]),
                .pad_out_o       (pad_out_o[gi]),
                .pad_oe_o        (pad_oe_o[gi]),
                .periph_in_o     (periph_in[gi]),
                .gpio_in_o       (gpio_in_o[gi])
            );
        end
    endgenerate

    assign ext_interrupt_in_o = periph_in[5:0];
    // test clocks always follow the pads, whatever gpio does
    assign test_clock_o       = pad_in_i[7:6];
    assign timer_capture_a_o  = {periph_in[18], periph_in[16], periph_in[14],
                                 periph_in[12], periph_in[10], periph_in[8]};
    assign timer_capture_b_o  = {periph_in[19], periph_in[17], periph_in[15],
                                 periph_in[13], periph_in[11], periph_in[9]};
    assign ext_timer_clock_src_o    = periph_in[23:20];
    assign uart0_receive_o          = periph_in[24];
    assign uart1_receive_o          = periph_in[26];
    assign uart1_clear_to_send_n_o  = periph_in[28];
    assign uart1_set_ready_n_o      = periph_in[29];
    assign uart1_carrier_detect_n_o = periph_in[30];
    assign uart1_ring_indicator_n_o = periph_in[31];
    assign smartcard_data_in_o      = periph_in[34];
endmodule
`default_nettype wire

// >>> hw/mfps_regs.vh
// constants for the multi-function pin select block
// Functional notes
// - port A pins 0-2 select clear gives interrupt inputs 0-2, set gives GPIO.
// - port A pins 3-5 select clear gives interrupt inputs 3-5, set gives GPIO.
// - port A pins 6-7 are GPIO only and also feed test clocks.
// - port B select clear routes even/odd pins to timer 0-3 captures A/B.
// - port C pins 0-3 select set routes to timer 4-5 captures, clear gives GPIO.
// - port C pins 4-7 select set routes to external timer clocks A-D.
// - port D pins 0-3 select clear gives UART0 rx/tx then UART1 rx/tx.
// - port D pins 4-7 select clear gives UART1 modem status inputs.
// - port E pins 0-1 select clear gives UART1 terminal-ready and request-send outputs.
// - port E pins 2-4 select clear gives smart-card data in, data out, clock.
`ifndef MFPS_REGS_VH
`define MFPS_REGS_VH
`define MFPS_SEL_A_ADDR  4'h0
`define MFPS_SEL_B_ADDR  4'h4
`define MFPS_SEL_C_ADDR  4'h8
`define MFPS_SEL_D_ADDR  4'hC
`define MFPS_SEL_E_ADDR  4'h0
`define MFPS_SEL_E_HI    1'b1
`define MFPS_SEL_A_RST   8'h00
`define MFPS_SEL_B_RST   8'h00
`define MFPS_SEL_C_RST   8'h00
`define MFPS_SEL_D_RST   8'h00
`define MFPS_SEL_E_RST   5'h00
`define MFPS_PORT_W      8
`define MFPS_E_W         5
`endif

// >>> hw/mfps_pin_cell.v
// one pin of the function multiplexer
`timescale 1ns/1ps
`default_nettype none
module mfps_pin_cell (
    // select
    input  wire sel_periph_i,
    input  wire periph_is_out_i,
    input  wire periph_out_i,
    // gpio
    input  wire gpio_oe_i,
    input  wire gpio_out_i,
    // pad
    input  wire pad_in_i,
    output wire pad_out_o,
    output wire pad_oe_o,
    // returned inputs
    output wire periph_in_o,
    output wire gpio_in_o
);
    // input-only functions never drive the pad
    assign pad_oe_o    = sel_periph_i ? periph_is_out_i : gpio_oe_i;
    assign pad_out_o   = sel_periph_i ? periph_out_i : gpio_out_i;
    // unselected peripheral sees idle high so active-low lines stay inactive
    assign periph_in_o = sel_periph_i ? pad_in_i : 1'b1;
    assign gpio_in_o   = pad_in_i;
endmodule
`default_nettype wire

// >>> verification/mfps_checker.sv
// assertion checker for the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module mfps_checker (
    // clock, reset and bus
    input wire logic        clk_i, rst_i, cyc_i, stb_i, ack_o,
    input wire logic [31:0] dat_o,
    // pins and routed inputs
    input wire logic [36:0] pad_in_i, pad_oe_o, gpio_in_o,
    input wire logic [5:0]  ext_interrupt_in_o, timer_capture_a_o, timer_capture_b_o,
    input wire logic [1:0]  test_clock_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    read_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("data off ack");
    test_clock_a: assert property (test_clock_o == pad_in_i[7:6]) else $error("tclk");
    gpio_in_a: assert property (gpio_in_o == pad_in_i) else $error("gpio in");
    irq_route_a: assert property ((~ext_interrupt_in_o & (pad_in_i[5:0] | pad_oe_o[5:0])) == 6'h00)
        else $error("irq route");
    cap_even_a: assert property ((~timer_capture_a_o & {pad_in_i[18], pad_in_i[16], pad_in_i[14],
        pad_in_i[12], pad_in_i[10], pad_in_i[8]}) == 6'h00) else $error("capture a");
    cap_odd_a: assert property ((~timer_capture_b_o & {pad_in_i[19], pad_in_i[17], pad_in_i[15],
        pad_in_i[13], pad_in_i[11], pad_in_i[9]}) == 6'h00) else $error("capture b");
    // reset itself is the cause here, so this one stays live during it
    reset_sel_a: assert property (disable iff (1'b0) rst_i |=> pad_oe_o[15:0] == 16'h00C0)
        else $error("reset select");
    cover property (ack_o && dat_o != 32'h0);
    cover property (ext_interrupt_in_o == 6'h3F && pad_oe_o[0]);
    cover property (pad_oe_o[23:16] == 8'h00);
endmodule
bind mfps_top mfps_checker chk (.*);
`default_nettype wire

// >>> verification/mfps_board.sv
// board-side pin model: a driven pad reads back its own level
`timescale 1ns/1ps
`default_nettype none
module mfps_board (
    input  wire logic [36:0] pad_out_i,
    input  wire logic [36:0] pad_oe_i,
    input  wire logic [36:0] board_i,
    output wire logic [36:0] pad_o
);
    // undriven pads show the board pattern, never a stale driven level
    assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & board_i);
endmodule
`default_nettype wire

// >>> verification/tb_mfps_top.sv
// testbench for the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_mfps_top;
    localparam logic [36:0] BRD = 37'h0A_5A5A_C3C3;
    localparam logic [36:0] GPO = 37'h15_A5A5_3C3C;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
    logic [4:0] adr_i = 5'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic [36:0] gpio_out_i = GPO, gpio_oe_i = {37{1'b1}}, gpio_in_o, pad_in_i, pad_out_o, pad_oe_o;
    logic [5:0] ext_interrupt_in_o, timer_capture_a_o, timer_capture_b_o, pout = 6'h2A;
    logic [3:0] ext_timer_clock_src_o;
    logic [1:0] test_clock_o;
    logic uart0_receive_o, uart1_receive_o, uart1_clear_to_send_n_o, uart1_set_ready_n_o,
          uart1_carrier_detect_n_o, uart1_ring_indicator_n_o, smartcard_data_in_o;
    logic uart0_transmit_i, uart1_transmit_i, uart1_terminal_ready_n_i, uart1_request_send_n_i,
          smartcard_data_out_i, smartcard_clock_out_i;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    assign {smartcard_clock_out_i, smartcard_data_out_i, uart1_request_send_n_i,
            uart1_terminal_ready_n_i, uart1_transmit_i, uart0_transmit_i} = pout;
    mfps_top DUT (.*);
    mfps_board board (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .board_i(BRD), .pad_o(pad_in_i));
    always #5 clk_i = ~clk_i;
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic t_default;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            pout <= k ? 6'h15 : 6'h2A;
            @(negedge clk_i);
            chk(64'({ext_interrupt_in_o, timer_capture_a_o, timer_capture_b_o, ext_timer_clock_src_o}),
                64'({BRD[5:0], 2'b11, BRD[14], BRD[12], BRD[10], BRD[8], 2'b11, BRD[15], BRD[13],
                BRD[11], BRD[9], 4'hF}));
            chk(64'({uart0_receive_o, uart1_receive_o, uart1_clear_to_send_n_o, uart1_set_ready_n_o,
                uart1_carrier_detect_n_o, uart1_ring_indicator_n_o, smartcard_data_in_o}),
                64'({BRD[24], BRD[26], BRD[28], BRD[29], BRD[30], BRD[31], BRD[34]}));
            chk(64'({pad_out_o[36:35], pad_out_o[33:32], pad_out_o[27], pad_out_o[25]}), 64'(pout));
            chk(64'(pad_oe_o), 64'(37'h1B_0AFF_00C0));
            chk(64'(test_clock_o), 64'(GPO[7:6]));
        end
        $display("default routing test done");
    endtask
    task automatic t_gpio;
        for (int i = 0; i < 5; i++) wb(1'b1, 5'(i * 4), 32'hFF, 4'hF);
        wb(1'b0, 5'h10, 32'h0, 4'hF);
        chk(64'(q), 64'h1F);
        @(negedge clk_i);
        chk(64'({ext_interrupt_in_o, timer_capture_a_o, timer_capture_b_o, ext_timer_clock_src_o}),
            64'({6'h3F, BRD[18], BRD[16], 4'hF, BRD[19], BRD[17], 4'hF, BRD[23:20]}));
        chk(64'({uart0_receive_o, uart1_receive_o, uart1_clear_to_send_n_o, smartcard_data_in_o}),
            64'hF);
        chk(64'(pad_oe_o), 64'(37'h1F_FF00_FFFF));
        chk(64'(pad_out_o[15:0]), 64'(GPO[15:0]));
        $display("select all test done");
    endtask
    task automatic t_refuse;
        wb(1'b1, 5'h14, 32'hFF, 4'hF);
        wb(1'b0, 5'h14, 32'h0, 4'hF);
        chk(64'(q), 64'h0);
        wb(1'b1, 5'h04, 32'h0, 4'h0);
        wb(1'b0, 5'h04, 32'h0, 4'hF);
        chk(64'(q), 64'hFF);
        for (int i = 0; i < 5; i++) wb(1'b1, 5'(i * 4), 32'h0, 4'hF);
        $display("refusal test done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_default();
        t_gpio();
        t_refuse();
        t_default();
        report_and_stop();
    end
endmodule
`default_nettype wire
